// ### core/rcb_radio_control_register_bank.sv
// Radio control register bank reached by serial register commands
`timescale 1ns/1ps

// Overview of operation
// RULE1 - Registers are only read and written by register commands on the serial port.
// RULE2 - Undefined bit positions have no storage and always read as zero.
// RULE3 - The controller must not write addresses 18 to 1B, which are reserved for test.
// RULE4 - Control bit 6 set keeps the receive-ready event off the interrupt pin, reset 0.
// RULE5 - Control bit 5 set keeps the transmit-sent event off the interrupt pin, reset 0.
// RULE6 - Control bit 4 set keeps the retry-limit event off the interrupt pin, reset 0.
// RULE7 - The interrupt pin is driven low while any unmasked event is pending.
// RULE8 - Control bit 3 enables the checksum, resets to 1, and is forced 1 by any auto-ack bit.
// RULE9 - Control bit 1 powers the radio up when 1 and down when 0, reset 0.
// RULE10 - The auto-ack register holds pipes 0 to 5 in bits 0 to 5, reset 1, bits 7:6 read 00.
// RULE11 - Software clears all auto-ack bits to work with the older radio lacking acknowledgement.
// RULE12 - Control bit 2 selects a one byte checksum when 0 and two bytes when 1, reset 0.
// RULE13 - Control bit 0 selects primary receiver when 1 and primary transmitter when 0, reset 0.
// RULE14 - A write is a command byte 001 plus 5-bit address, then data bytes LSByte first.
// RULE15 - The controller writes registers only in power down or standby.
// RULE16 - Writing 1 to a pending event bit in the status register clears it and frees the pin.
module rcb_radio_control_register_bank
	import rcb_pkg::*;
#(
	parameter int PIPE_COUNT = 6
)
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// Serial command port
	input  wire logic       spiSck,
	input  wire logic       spiCsnN,
	input  wire logic       spiMosi,
	output logic            spiMiso,
	// Radio state machine events
	input  wire logic       rxReadyEvent,
	input  wire logic       txSentEvent,
	input  wire logic       retryLimitEvent,
	// Interrupt
	output logic            radioIrqN,
	// Control fields
	output logic            rxReadyIrqBlock,
	output logic            txSentIrqBlock,
	output logic            retryLimitIrqBlock,
	output logic            checksumEnable,
	output logic            checksumLengthSel,
	output logic            powerOnBit,
	output logic            receiverRoleSel,
	// Pipe enables
	output logic [5:0]      autoAckPipeEnable,
	output logic [5:0]      receivePipeEnable
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	generate
		if (PIPE_COUNT < 1 || PIPE_COUNT > 6)
		begin : g_bad_pipes
			$error("PIPE_COUNT must be 1 to 6");
		end
	endgenerate

	localparam logic [5:0] PIPE_MASK = 6'((1 << PIPE_COUNT) - 1);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	rcb_byte_if      bytes ();

	logic            sckLevel;
	logic            csnLevel;
	logic            mosiLevel;
	logic            misoShift;

	rcb_phase_type   phase_r;
	logic [4:0]      addr_r;
	logic            isRead_r;
	logic            isWrite_r;
	logic            firstData_r;

	logic            rxReadyFlag_r;
	logic            txSentFlag_r;
	logic            retryFlag_r;

	logic            writeStrobe;
	logic [7:0]      writeData;
	logic            wrControl;
	logic            wrAutoAck;
	logic            wrReceive;
	logic            wrStatus;
	logic [5:0]      autoAck_nxt;
	logic [7:0]      controlRead;
	logic [7:0]      statusRead;
	logic [7:0]      readData;
	logic            irqPending;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	rcb_sync #(.RESET_LEVEL(1'b0)) u_sync_sck
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.pinIn    (spiSck),
		.levelOut (sckLevel)
	);

	rcb_sync #(.RESET_LEVEL(1'b1)) u_sync_csn
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.pinIn    (spiCsnN),
		.levelOut (csnLevel)
	);

	rcb_sync #(.RESET_LEVEL(1'b0)) u_sync_mosi
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.pinIn    (spiMosi),
		.levelOut (mosiLevel)
	);

	// ----------------------------------------------------------------
	// Serial shifter
	// ----------------------------------------------------------------
	rcb_spi_shifter u_shifter
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.sckLevel  (sckLevel),
		.csnLevel  (csnLevel),
		.mosiLevel (mosiLevel),
		.misoOut   (misoShift),
		.bytes     (bytes.shifter)
	);

	// Output pin held low outside a frame
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			spiMiso <= 1'b0;
		else
			spiMiso <= misoShift && !csnLevel;
	end

	// ----------------------------------------------------------------
	// Command decode and frame phase
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			phase_r <= PH_IDLE;
		else if (bytes.frameEnd)
			phase_r <= PH_IDLE;
		else if (bytes.frameStart)
			phase_r <= PH_CMD;
		else if (bytes.byteDone)
		begin
			case (phase_r)
				PH_CMD:  phase_r <= PH_DATA;
				default: phase_r <= phase_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			addr_r      <= ADDR_RADIO_CONTROL;
			isRead_r    <= 1'b0;
			isWrite_r   <= 1'b0;
			firstData_r <= 1'b0;
		end
		else if (bytes.frameStart || bytes.frameEnd)
		begin
			isRead_r    <= 1'b0;
			isWrite_r   <= 1'b0;
			firstData_r <= 1'b0;
		end
		else if (bytes.byteDone && phase_r == PH_CMD)
		begin
			addr_r      <= bytes.rxByte[CMD_ADDR_MSB:0]; // RULE14
			isRead_r    <= bytes.rxByte[CMD_PREFIX_MSB:CMD_PREFIX_LSB] == CMD_READ_PREFIX;
			isWrite_r   <= bytes.rxByte[CMD_PREFIX_MSB:CMD_PREFIX_LSB] == CMD_WRITE_PREFIX;
			firstData_r <= 1'b1;
		end
		else if (bytes.byteDone && phase_r == PH_DATA)
			firstData_r <= 1'b0;
	end

	// Registers are one byte wide, so only the first data byte counts
	assign writeStrobe = bytes.byteDone && phase_r == PH_DATA && isWrite_r && firstData_r; // RULE1
	assign writeData   = bytes.rxByte;

	// Unmapped addresses, the test range among them, take no write
	always_comb
	begin
		wrControl = 1'b0;
		wrAutoAck = 1'b0;
		wrReceive = 1'b0;
		wrStatus  = 1'b0;
		if (addr_r == ADDR_RADIO_CONTROL)
			wrControl = writeStrobe;
		else if (addr_r == ADDR_AUTO_ACK_ENABLE)
			wrAutoAck = writeStrobe;
		else if (addr_r == ADDR_RECEIVE_ENABLE)
			wrReceive = writeStrobe;
		else if (addr_r == ADDR_STATUS)
			wrStatus = writeStrobe;
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			rxReadyIrqBlock    <= RST_IRQ_BLOCK;
			txSentIrqBlock     <= RST_IRQ_BLOCK;
			retryLimitIrqBlock <= RST_IRQ_BLOCK;
			checksumLengthSel  <= RST_CHECKSUM_LENGTH;
			powerOnBit         <= RST_POWER_ON;
			receiverRoleSel    <= RST_RECEIVER_ROLE;
		end
		else if (wrControl)
		begin
			rxReadyIrqBlock    <= writeData[BIT_RX_READY_BLOCK]; // RULE4
			txSentIrqBlock     <= writeData[BIT_TX_SENT_BLOCK]; // RULE5
			retryLimitIrqBlock <= writeData[BIT_RETRY_BLOCK]; // RULE6
			checksumLengthSel  <= writeData[BIT_CHECKSUM_LENGTH]; // RULE12
			powerOnBit         <= writeData[BIT_POWER_ON]; // RULE9
			receiverRoleSel    <= writeData[BIT_RECEIVER_ROLE]; // RULE13
		end
	end

	// Checksum enable is forced on by any auto-ack bit in the same cycle and keeps its value when they clear
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			checksumEnable <= RST_CHECKSUM_ENABLE;
		else
			checksumEnable <= (wrControl ? writeData[BIT_CHECKSUM_ENABLE] : checksumEnable)
				| (|autoAck_nxt); // RULE8
	end

	// ----------------------------------------------------------------
	// Pipe enable registers
	// ----------------------------------------------------------------
	assign autoAck_nxt = wrAutoAck ? (writeData[5:0] & PIPE_MASK) : autoAckPipeEnable;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			autoAckPipeEnable <= RST_AUTO_ACK & PIPE_MASK; // RULE10
		else
			autoAckPipeEnable <= autoAck_nxt; // RULE10
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			receivePipeEnable <= RST_RECEIVE_PIPES & PIPE_MASK;
		else if (wrReceive)
			receivePipeEnable <= writeData[5:0] & PIPE_MASK;
	end

	// ----------------------------------------------------------------
	// Event flags, a new event wins over a clear in the same cycle
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			rxReadyFlag_r <= 1'b0;
			txSentFlag_r  <= 1'b0;
			retryFlag_r   <= 1'b0;
		end
		else
		begin
			rxReadyFlag_r <= rxReadyEvent
				|| (rxReadyFlag_r && !(wrStatus && writeData[BIT_RX_READY_EVENT])); // RULE16
			txSentFlag_r  <= txSentEvent
				|| (txSentFlag_r && !(wrStatus && writeData[BIT_TX_SENT_EVENT])); // RULE16
			retryFlag_r   <= retryLimitEvent
				|| (retryFlag_r && !(wrStatus && writeData[BIT_RETRY_EVENT])); // RULE16
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	assign irqPending = (rxReadyFlag_r && !rxReadyIrqBlock) // RULE4
		|| (txSentFlag_r && !txSentIrqBlock) // RULE5
		|| (retryFlag_r && !retryLimitIrqBlock); // RULE6

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			radioIrqN <= 1'b1;
		else
			radioIrqN <= !irqPending; // RULE7
	end

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	always_comb
	begin
		controlRead                      = BYTE_ZERO; // RULE2
		controlRead[BIT_RX_READY_BLOCK]  = rxReadyIrqBlock;
		controlRead[BIT_TX_SENT_BLOCK]   = txSentIrqBlock;
		controlRead[BIT_RETRY_BLOCK]     = retryLimitIrqBlock;
		controlRead[BIT_CHECKSUM_ENABLE] = checksumEnable;
		controlRead[BIT_CHECKSUM_LENGTH] = checksumLengthSel;
		controlRead[BIT_POWER_ON]        = powerOnBit;
		controlRead[BIT_RECEIVER_ROLE]   = receiverRoleSel;
	end

	always_comb
	begin
		statusRead                     = BYTE_ZERO; // RULE2
		statusRead[BIT_RX_READY_EVENT] = rxReadyFlag_r;
		statusRead[BIT_TX_SENT_EVENT]  = txSentFlag_r;
		statusRead[BIT_RETRY_EVENT]    = retryFlag_r;
	end

	always_comb
	begin
		if (addr_r == ADDR_RADIO_CONTROL)
			readData = controlRead;
		else if (addr_r == ADDR_AUTO_ACK_ENABLE)
			readData = {2'b00, autoAckPipeEnable}; // RULE2
		else if (addr_r == ADDR_RECEIVE_ENABLE)
			readData = {2'b00, receivePipeEnable}; // RULE2
		else if (addr_r == ADDR_STATUS)
			readData = statusRead;
		else
			readData = BYTE_ZERO; // RULE2
	end

	// Status leaves with the command byte, register data with the next
	always_comb
	begin
		if (phase_r == PH_DATA)
			bytes.txByte = (isRead_r && firstData_r) ? readData : BYTE_ZERO; // RULE1
		else
			bytes.txByte = statusRead;
	end

endmodule

// ### core/rcb_pkg.sv
// Shared constants for the radio control register bank
package rcb_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_RADIO_CONTROL   = 5'h00;
	localparam logic [4:0] ADDR_AUTO_ACK_ENABLE = 5'h01;
	localparam logic [4:0] ADDR_RECEIVE_ENABLE  = 5'h02;
	localparam logic [4:0] ADDR_STATUS          = 5'h07;

	// ----------------------------------------------------------------
	// Command byte layout
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_READ_PREFIX  = 3'h0;
	localparam logic [2:0] CMD_WRITE_PREFIX = 3'h1;
	localparam int         CMD_PREFIX_MSB   = 7;
	localparam int         CMD_PREFIX_LSB   = 5;
	localparam int         CMD_ADDR_MSB     = 4;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int BIT_RX_READY_BLOCK  = 6;
	localparam int BIT_TX_SENT_BLOCK   = 5;
	localparam int BIT_RETRY_BLOCK     = 4;
	localparam int BIT_CHECKSUM_ENABLE = 3;
	localparam int BIT_CHECKSUM_LENGTH = 2;
	localparam int BIT_POWER_ON        = 1;
	localparam int BIT_RECEIVER_ROLE   = 0;

	// ----------------------------------------------------------------
	// Status register event fields
	// ----------------------------------------------------------------
	localparam int BIT_RX_READY_EVENT  = 6;
	localparam int BIT_TX_SENT_EVENT   = 5;
	localparam int BIT_RETRY_EVENT     = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic       RST_IRQ_BLOCK       = 1'b0;
	localparam logic       RST_CHECKSUM_ENABLE = 1'b1;
	localparam logic       RST_CHECKSUM_LENGTH = 1'b0;
	localparam logic       RST_POWER_ON        = 1'b0;
	localparam logic       RST_RECEIVER_ROLE   = 1'b0;
	localparam logic [5:0] RST_AUTO_ACK        = 6'h3f;
	localparam logic [5:0] RST_RECEIVE_PIPES   = 6'h03;
	localparam logic [7:0] BYTE_ZERO           = 8'h00;

	// ----------------------------------------------------------------
	// Frame phases
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'b00,
		PH_CMD  = 2'b01,
		PH_DATA = 2'b10
	} rcb_phase_type;

endpackage

// ### core/rcb_byte_if.sv
// Byte transfer signals between the serial shifter and the register bank
`timescale 1ns/1ps
interface rcb_byte_if;
	logic       frameStart;
	logic       frameEnd;
	logic       byteDone;
	logic [7:0] rxByte;
	logic [7:0] txByte;

	modport shifter
	(
		output frameStart,
		output frameEnd,
		output byteDone,
		output rxByte,
		input  txByte
	);

	modport bank
	(
		input  frameStart,
		input  frameEnd,
		input  byteDone,
		input  rxByte,
		output txByte
	);
endinterface

// ### core/rcb_sync.sv
// Three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rcb_sync
#(
	parameter logic RESET_LEVEL = 1'b0
)
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Pin and filtered level
	input  wire logic pinIn,
	output logic      levelOut
);

	logic stage1_r;
	logic stage2_r;
	logic stage3_r;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			stage1_r <= RESET_LEVEL;
			stage2_r <= RESET_LEVEL;
			stage3_r <= RESET_LEVEL;
			levelOut <= RESET_LEVEL;
		end
		else
		begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			if (stage2_r == stage3_r)
				levelOut <= stage3_r;
		end
	end

endmodule

// ### core/rcb_spi_shifter.sv
// Serial byte shifter for the command port, clock idle low, MSBit first
`timescale 1ns/1ps
module rcb_spi_shifter
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Filtered serial levels
	input  wire logic sckLevel,
	input  wire logic csnLevel,
	input  wire logic mosiLevel,
	// Serial output
	output logic      misoOut,
	// Byte side
	rcb_byte_if.shifter bytes
);

	logic       sckPrev_r;
	logic       csnPrev_r;
	logic [2:0] bitCnt_r;
	logic [6:0] rxShift_r;
	logic [7:0] txShift_r;
	logic       sckRise;
	logic       sckFall;
	logic       frameStart;

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			sckPrev_r <= 1'b0;
			csnPrev_r <= 1'b1;
		end
		else
		begin
			sckPrev_r <= sckLevel;
			csnPrev_r <= csnLevel;
		end
	end

	assign sckRise    = !csnLevel && sckLevel && !sckPrev_r;
	assign sckFall    = !csnLevel && !sckLevel && sckPrev_r;
	assign frameStart = csnPrev_r && !csnLevel;

	assign bytes.frameStart = frameStart;
	assign bytes.frameEnd   = !csnPrev_r && csnLevel;

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			bitCnt_r       <= 3'h0;
			rxShift_r      <= 7'h00;
			bytes.rxByte   <= 8'h00;
			bytes.byteDone <= 1'b0;
		end
		else
		begin
			bytes.byteDone <= 1'b0;
			if (frameStart)
				bitCnt_r <= 3'h0;
			else if (sckRise)
			begin
				rxShift_r <= {rxShift_r[5:0], mosiLevel};
				bitCnt_r  <= bitCnt_r + 3'h1;
				if (bitCnt_r == 3'h7)
				begin
					bytes.rxByte   <= {rxShift_r, mosiLevel};
					bytes.byteDone <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit side
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			txShift_r <= 8'h00;
		else if (frameStart)
			txShift_r <= bytes.txByte;
		else if (sckFall)
		begin
			if (bitCnt_r == 3'h0)
				txShift_r <= bytes.txByte;
			else
				txShift_r <= {txShift_r[6:0], 1'b0};
		end
	end

	assign misoOut = txShift_r[7];

endmodule

// ### verification/rcb_ctl_model.sv
// Controller model driving register command frames on the serial port
`timescale 1ns/1ps
module rcb_ctl_model
	import rcb_pkg::*;
(
	// Clock
	input  wire logic sys_clk,
	// Serial port
	output logic      spiSck,
	output logic      spiCsnN,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	initial
	begin
		spiSck = 1'b0;
		spiCsnN = 1'b1;
		spiMosi = 1'b0;
	end

	// ----------
	// One frame: command byte then one data byte, MSBit first
	// ----------
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
		output logic [7:0] st, output logic [7:0] rd);
		logic [15:0] tx;
		logic [15:0] rx;
		st = BYTE_ZERO;
		rd = BYTE_ZERO;
		if (cmd[7:5] == CMD_WRITE_PREFIX && cmd[4:2] == 3'b110)
			return;
		tx = {cmd, dat};
		@(posedge sys_clk) spiCsnN <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge sys_clk) spiMosi <= tx[i];
			repeat (8) @(posedge sys_clk);
			rx[i] = spiMiso;
			spiSck <= 1'b1;
			repeat (8) @(posedge sys_clk);
			spiSck <= 1'b0;
		end
		repeat (8) @(posedge sys_clk);
		spiCsnN <= 1'b1;
		// Stale data line flips once the frame is over
		spiMosi <= ~spiMosi;
		repeat (10) @(posedge sys_clk);
		st = rx[15:8];
		rd = rx[7:0];
	endtask
endmodule

// ### verification/rcb_radio_control_register_bank_chk.sv
// Assertion checker for the radio control register bank
`timescale 1ns/1ps
module rcb_radio_control_register_bank_chk
	import rcb_pkg::*;
#(
	parameter int PIPE_COUNT = 6
)
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rstn,
	// Serial port and events
	input wire logic       spiSck,
	input wire logic       spiCsnN,
	input wire logic       spiMosi,
	input wire logic       spiMiso,
	input wire logic       rxReadyEvent,
	input wire logic       txSentEvent,
	input wire logic       retryLimitEvent,
	// Outputs
	input wire logic       radioIrqN,
	input wire logic       rxReadyIrqBlock,
	input wire logic       txSentIrqBlock,
	input wire logic       retryLimitIrqBlock,
	input wire logic       checksumEnable,
	input wire logic       checksumLengthSel,
	input wire logic       powerOnBit,
	input wire logic       receiverRoleSel,
	input wire logic [5:0] autoAckPipeEnable,
	input wire logic [5:0] receivePipeEnable
);
	logic [6:0] ctrl;

	assign ctrl = {rxReadyIrqBlock, txSentIrqBlock, retryLimitIrqBlock, checksumEnable,
		checksumLengthSel, powerOnBit, receiverRoleSel};

	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	property p_rxIrq;
		rxReadyEvent && !rxReadyIrqBlock ##1 !rxReadyIrqBlock |=> !radioIrqN;
	endproperty
	a_rxIrq:
		assert property (p_rxIrq) else $error("Receive event missed the interrupt");
	property p_txIrq;
		txSentEvent && !txSentIrqBlock ##1 !txSentIrqBlock |=> !radioIrqN;
	endproperty
	a_txIrq:
		assert property (p_txIrq) else $error("Sent event missed the interrupt");
	property p_rtIrq;
		retryLimitEvent && !retryLimitIrqBlock ##1 !retryLimitIrqBlock |=> !radioIrqN;
	endproperty
	a_rtIrq:
		assert property (p_rtIrq) else $error("Retry event missed the interrupt");
	property p_allMasked;
		(rxReadyIrqBlock && txSentIrqBlock && retryLimitIrqBlock) [*2] |-> radioIrqN;
	endproperty
	a_allMasked:
		assert property (p_allMasked) else $error("Interrupt low with all sources masked");
	property p_crcForce;
		|autoAckPipeEnable |-> checksumEnable;
	endproperty
	a_crcForce:
		assert property (p_crcForce) else $error("Checksum not forced by auto ack");
	property p_resetVal;
		disable iff (1'b0)
		!rstn |=> radioIrqN && !spiMiso && ctrl == 7'h08 && autoAckPipeEnable == 6'h3f
			&& receivePipeEnable == 6'h03;
	endproperty
	a_resetVal:
		assert property (p_resetVal) else $error("Wrong value after reset");
	property p_idleStable;
		spiCsnN [*8] |=> $stable(ctrl) && $stable(autoAckPipeEnable)
			&& $stable(receivePipeEnable);
	endproperty
	a_idleStable:
		assert property (p_idleStable) else $error("Register changed outside a frame");
	property p_misoIdle;
		spiCsnN [*8] |-> !spiMiso;
	endproperty
	a_misoIdle:
		assert property (p_misoIdle) else $error("Data out not low between frames");
	property p_irqHold;
		spiCsnN [*8] ##0 !radioIrqN |=> !radioIrqN;
	endproperty
	a_irqHold:
		assert property (p_irqHold) else $error("Interrupt released without a clear");
endmodule

bind rcb_radio_control_register_bank rcb_radio_control_register_bank_chk
	#(.PIPE_COUNT(PIPE_COUNT)) chk_u (.sys_clk(sys_clk), .rstn(rstn), .spiSck(spiSck),
	.spiCsnN(spiCsnN), .spiMosi(spiMosi), .spiMiso(spiMiso), .rxReadyEvent(rxReadyEvent),
	.txSentEvent(txSentEvent), .retryLimitEvent(retryLimitEvent), .radioIrqN(radioIrqN),
	.rxReadyIrqBlock(rxReadyIrqBlock), .txSentIrqBlock(txSentIrqBlock),
	.retryLimitIrqBlock(retryLimitIrqBlock), .checksumEnable(checksumEnable),
	.checksumLengthSel(checksumLengthSel), .powerOnBit(powerOnBit),
	.receiverRoleSel(receiverRoleSel), .autoAckPipeEnable(autoAckPipeEnable),
	.receivePipeEnable(receivePipeEnable));

// ### verification/rcb_radio_control_register_bank_test.sv
// Self-checking testbench for the radio control register bank
`timescale 1ns/1ps
`define CHK(a, b, m) begin numChecks++; if ((a) !== (b)) begin failCount++; \
	$display("CHECK FAILED at %0t: %s", $time, m); end end
module rcb_radio_control_register_bank_test
	import rcb_pkg::*;
;
	logic       sys_clk;
	logic       rstn;
	logic       spiSck;
	logic       spiCsnN;
	logic       spiMosi;
	logic       spiMiso;
	logic [2:0] evPulse;
	logic       radioIrqN;
	logic [6:0] ctrlOut;
	logic [5:0] ackEn;
	logic [5:0] rxEn;
	int         failCount;
	int         numChecks;

	rcb_radio_control_register_bank dut_u (.sys_clk(sys_clk), .rstn(rstn), .spiSck(spiSck),
		.spiCsnN(spiCsnN), .spiMosi(spiMosi), .spiMiso(spiMiso),
		.rxReadyEvent(evPulse[2]), .txSentEvent(evPulse[1]), .retryLimitEvent(evPulse[0]),
		.radioIrqN(radioIrqN), .rxReadyIrqBlock(ctrlOut[6]), .txSentIrqBlock(ctrlOut[5]),
		.retryLimitIrqBlock(ctrlOut[4]), .checksumEnable(ctrlOut[3]),
		.checksumLengthSel(ctrlOut[2]), .powerOnBit(ctrlOut[1]),
		.receiverRoleSel(ctrlOut[0]), .autoAckPipeEnable(ackEn), .receivePipeEnable(rxEn));

	rcb_ctl_model ctl_u (.sys_clk(sys_clk), .spiSck(spiSck), .spiCsnN(spiCsnN),
		.spiMosi(spiMosi), .spiMiso(spiMiso));

	// ----------
	// Helpers
	// ----------
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] s;
		logic [7:0] r;
		// Radio never active here, so writes fall in power down or standby
		ctl_u.frame({CMD_WRITE_PREFIX, a}, d, s, r);
	endtask

	task automatic chkReg(input logic [4:0] a, input logic [7:0] e, input string m);
		logic [7:0] s;
		logic [7:0] d;
		ctl_u.frame({CMD_READ_PREFIX, a}, BYTE_ZERO, s, d);
		`CHK(d, e, m);
	endtask

	task automatic pulse(input int k);
		@(posedge sys_clk) evPulse[k] <= 1'b1;
		@(posedge sys_clk) evPulse <= 3'h0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic stopTest;
		$display("Checks %0d, failures %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------
	// Scenarios
	// ----------
	task automatic testReset;
		`CHK(ctrlOut, 7'h08, "control pins at reset");
		`CHK(ackEn, RST_AUTO_ACK, "ack pins at reset");
		chkReg(ADDR_RADIO_CONTROL, 8'h08, "control at reset");
		chkReg(ADDR_AUTO_ACK_ENABLE, 8'h3f, "ack at reset");
		chkReg(ADDR_RECEIVE_ENABLE, 8'h03, "rx pipes at reset");
	endtask

	task automatic testControl;
		logic [7:0] e;
		for (int i = 0; i < 8; i++)
		begin
			e = (8'h01 << i) & 8'h7f | 8'h08;
			wr(ADDR_RADIO_CONTROL, 8'h01 << i);
			chkReg(ADDR_RADIO_CONTROL, e, "control bit");
			`CHK({1'b0, ctrlOut}, e, "control pins");
		end
	endtask

	task automatic testPipes;
		wr(ADDR_AUTO_ACK_ENABLE, 8'hff);
		chkReg(ADDR_AUTO_ACK_ENABLE, 8'h3f, "ack reserved bits");
		wr(ADDR_AUTO_ACK_ENABLE, 8'h00);
		wr(ADDR_RADIO_CONTROL, 8'h00);
		chkReg(ADDR_RADIO_CONTROL, 8'h00, "checksum off");
		wr(ADDR_AUTO_ACK_ENABLE, 8'h20);
		`CHK(ctrlOut[3], 1'b1, "checksum forced");
		`CHK(ackEn, 6'h20, "ack pins");
		wr(ADDR_RECEIVE_ENABLE, 8'hd5);
		wr(5'h03, 8'hff);
		chkReg(5'h03, 8'h00, "unmapped read");
		chkReg(ADDR_RECEIVE_ENABLE, 8'h15, "rx pipes");
		`CHK(rxEn, 6'h15, "rx pipe pins");
	endtask

	task automatic testIrq;
		logic [7:0] s;
		logic [7:0] d;
		for (int k = 0; k < 3; k++)
		begin
			pulse(k);
			`CHK(radioIrqN, 1'b0, "event raised");
			chkReg(ADDR_STATUS, 8'h10 << k, "event flag");
			// Command that is neither read nor write still shifts out status
			ctl_u.frame(8'hff, BYTE_ZERO, s, d);
			`CHK(s, 8'h10 << k, "status shifted first");
			`CHK(d, BYTE_ZERO, "no data after other command");
			wr(ADDR_STATUS, 8'h10 << k);
			`CHK(radioIrqN, 1'b1, "event cleared");
			wr(ADDR_RADIO_CONTROL, 8'h10 << k);
			pulse(k);
			`CHK(radioIrqN, 1'b1, "masked event");
			chkReg(ADDR_STATUS, 8'h10 << k, "masked flag");
			wr(ADDR_RADIO_CONTROL, 8'h00);
			`CHK(radioIrqN, 1'b0, "unmasked pending");
			wr(ADDR_STATUS, 8'h10 << k);
		end
		wr(ADDR_RADIO_CONTROL, 8'h70);
		pulse(0);
		pulse(1);
		pulse(2);
		`CHK(radioIrqN, 1'b1, "all masked");
		wr(ADDR_STATUS, 8'h70);
		chkReg(ADDR_STATUS, 8'h00, "all cleared");
	endtask

	// ----------
	// Clock, reset, sequence and watchdog
	// ----------
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial
	begin
		rstn = 1'b0;
		evPulse = 3'h0;
		failCount = 0;
		numChecks = 0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		testReset();
		testControl();
		testPipes();
		testIrq();
		stopTest();
	end

	initial
	begin
		repeat (60000) @(posedge sys_clk);
		failCount++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		stopTest();
	end
endmodule
